// File: core/conv_pkg.sv
`default_nettype none
package conv_pkg;
  localparam int RES_BITS = 10;
  localparam int PAIR_BITS = 16;
  localparam int SIGN_EXT_BITS = 6;
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 6500;
  localparam int ADC_CONV_CYCLES = 13;
  localparam int DAC_CONV_CYCLES = 11;
  localparam int ADC_SAMPLE_CYCLE = 3;
  localparam int DAC_DRIVE_CYCLE = 7;
  localparam int CONV_CLK_PERIOD_NS = CONV_TIME_NS / ADC_CONV_CYCLES;
  localparam int TICK_DIV = CONV_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  localparam logic [TICK_W-1:0] TICK_ONE = 5'h01;
  localparam logic [3:0] PH_ZERO = 4'h0;
  localparam logic [3:0] PH_ONE = 4'h1;
  localparam logic [3:0] PH_SAMPLE_START = 4'(ADC_SAMPLE_CYCLE - 1);
  localparam logic [3:0] PH_SAMPLE_END = 4'(ADC_SAMPLE_CYCLE);
  localparam logic [3:0] PH_ADC_END = 4'(ADC_CONV_CYCLES);
  localparam logic [3:0] PH_DAC_END = 4'(DAC_CONV_CYCLES);
  localparam logic [3:0] PH_DRIVE = 4'(DAC_DRIVE_CYCLE - 1);
  localparam logic [3:0] PH_BUILD_LAST = 4'(RES_BITS);
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MIDSCALE = 10'h200;
  localparam logic [9:0] CODE_MSB_TRIAL = 10'h200;
  localparam logic [9:0] CODE_NEG_OVER = 10'h200;
  localparam logic [9:0] CODE_NEG_FULL = 10'h201;
  localparam logic [9:0] BIT_ONE = 10'h001;
  localparam logic [5:0] ZERO_FILL = 6'h00;
  localparam logic [15:0] PAIR_RESET = 16'h0000;
  localparam logic [15:0] RIGHT_OVERRANGE = 16'hFE00;
  localparam logic [15:0] LEFT_OVERRANGE = 16'h8000;
  localparam logic [7:0] READ_BLANK = 8'h00;
  localparam logic [2:0] SE_CHANNELS = 3'h7;
  localparam logic [2:0] DIFFERENTIAL_SELECT_PAIRS = 3'h3;
  localparam logic [2:0] CH_RESET = 3'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADC = 2'b01,
    ST_DAC = 2'b10
  } conv_state_t;
endpackage
`default_nettype wire

// File: core/fmt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fmt_if;
  logic [9:0] adcCode;
  logic leftAdj;
  logic [15:0] adcPair;
  logic [15:0] dacPair;
  logic [9:0] dacCode;
  modport ctrl (output adcCode, output leftAdj, output dacPair, input adcPair, input dacCode);
  modport fmt (input adcCode, input leftAdj, input dacPair, output adcPair, output dacCode);
endinterface
`default_nettype wire

// File: core/conv_tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
module conv_tick_divider
  import conv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  output logic tick
);
  logic [TICK_W-1:0] divCnt_q;
  wire logic atLast = (divCnt_q == TICK_LAST);
  wire logic [TICK_W-1:0] divCnt_d = atLast ? '0 : divCnt_q + TICK_ONE;

  // free running: a start waits up to one converter cycle for the first tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= '0;
      tick <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tick <= atLast;
    end
  end
endmodule
`default_nettype wire

// File: core/result_formatter.sv
`timescale 1ns/10ps
`default_nettype none
module result_formatter
  import conv_pkg::*;
(
  fmt_if.fmt fmtBus
);
  // sar word is offset binary; flipping the msb gives two's complement
  wire logic [9:0] twosRaw = fmtBus.adcCode ^ CODE_MIDSCALE;
  // code range is symmetric, the lone -512 code folds onto -511
  wire logic [9:0] twosCode = (twosRaw == CODE_NEG_OVER) ? CODE_NEG_FULL : twosRaw;
  wire logic [15:0] rightPair = {{SIGN_EXT_BITS{twosCode[RES_BITS-1]}}, twosCode};
  wire logic [15:0] leftPair = {twosCode, ZERO_FILL};
  wire logic [9:0] dacTwos = fmtBus.leftAdj ? fmtBus.dacPair[PAIR_BITS-1 -: RES_BITS]
                                            : fmtBus.dacPair[RES_BITS-1:0];

  assign fmtBus.adcPair = fmtBus.leftAdj ? leftPair : rightPair;
  assign fmtBus.dacCode = dacTwos ^ CODE_MIDSCALE;
endmodule
`default_nettype wire

// File: core/conv_control.sv
`timescale 1ns/10ps
`default_nettype none
module conv_control
  import conv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic converterEnableBit,
  input wire logic dacMode,
  input wire logic leftAdjustSelect,
  input wire logic differentialSelect,
  input wire logic [2:0] channelSelect,
  input wire logic goSet,
  input wire logic timerTrigger,
  input wire logic timerTrigEnable,
  input wire logic doneClear,
  input wire logic pairWriteHigh,
  input wire logic pairWriteLow,
  input wire logic [7:0] pairWriteData,
  input wire logic compAboveRaw,
  output logic [7:0] resultHighByte,
  output logic [7:0] resultLowByte,
  output logic conversionGoFlag,
  output logic conversionDoneFlag,
  output logic doneIrq,
  output logic sampleHold,
  output logic [9:0] analogCode,
  output logic dacDrive,
  output logic [2:0] muxChannel,
  output logic muxDiff,
  output logic muxConnect
);
  conv_state_t state_q, stateD;
  logic [3:0] phase_q;
  logic [9:0] sar_q, sarD;
  logic [9:0] dacBuf_q;
  logic [15:0] pair_q, pairD;
  logic [7:0] rdHigh_q, rdLow_q;
  logic go_q, done_q, irq_q, hold_q, drive_q;
  logic [2:0] muxCh_q;
  logic muxDiff_q, muxConn_q;
  logic compSync1_q, compSync2_q;
  logic tick;

  fmt_if fmtBus ();

  conv_tick_divider u_divider (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  result_formatter u_formatter (
    .fmtBus(fmtBus)
  );

  wire logic idle = (state_q == ST_IDLE);
  wire logic swStart = goSet;
  wire logic hwStart = timerTrigger && timerTrigEnable;
  wire logic startReq = (swStart || hwStart) && converterEnableBit && idle;
  wire logic abort = !idle && !converterEnableBit;
  wire logic tickAdc = tick && converterEnableBit && (state_q == ST_ADC);
  wire logic tickDac = tick && converterEnableBit && (state_q == ST_DAC);
  wire logic adcEnd = tickAdc && (phase_q == PH_ADC_END);
  wire logic dacEnd = tickDac && (phase_q == PH_DAC_END);
  wire logic finish = adcEnd || dacEnd;

  // adc trial: bit under test is decided by the synchronised comparator
  wire logic [3:0] bitIdx = PH_ADC_END - phase_q;
  wire logic [9:0] bitMask = BIT_ONE << bitIdx;
  wire logic [9:0] sarKept = compSync2_q ? sar_q : (sar_q & ~bitMask);
  wire logic [9:0] sarStep = sarKept | (bitMask >> 1);
  // dac build: buffered bits revealed msb first from the second cycle
  wire logic [3:0] dacShift = phase_q - PH_ONE;
  wire logic [9:0] dacMask = CODE_MSB_TRIAL >> dacShift;
  wire logic [9:0] dacBuilt = (sar_q & ~dacMask) | (dacBuf_q & dacMask);
  wire logic dacBuildTick = tickDac && (phase_q != PH_ZERO) && (phase_q <= PH_BUILD_LAST);

  wire logic chanValid = differentialSelect ? (channelSelect < DIFFERENTIAL_SELECT_PAIRS)
                                            : (channelSelect < SE_CHANNELS);
  wire logic pairWrEn = dacMode && (state_q != ST_ADC);
  wire logic pairWrAny = pairWrEn && (pairWriteHigh || pairWriteLow);
  wire logic [3:0] phaseD = idle ? PH_ZERO : (tick ? phase_q + PH_ONE : phase_q);
  wire logic goD = startReq || (go_q && !finish && !abort);
  // a completion in the clear cycle still leaves the flag set
  wire logic doneD = finish || (done_q && !doneClear);
  wire logic adcRun = (state_q == ST_ADC) && converterEnableBit;
  wire logic holdD = !adcRun ? 1'b0 :
                     (tickAdc && phase_q == PH_SAMPLE_START) ? 1'b1 :
                     (tickAdc && phase_q == PH_SAMPLE_END) ? 1'b0 : hold_q;
  wire logic driveD = (!(dacMode && converterEnableBit) || startReq) ? 1'b0 :
                      (tickDac && phase_q == PH_DRIVE) ? 1'b1 : drive_q;
  // dac pair reads as blank; readback lags the pair by one cycle
  wire logic [7:0] rdHighD = dacMode ? READ_BLANK : pair_q[15:8];
  wire logic [7:0] rdLowD = dacMode ? READ_BLANK : pair_q[7:0];

  assign fmtBus.adcCode = sarKept;
  assign fmtBus.leftAdj = leftAdjustSelect;
  assign fmtBus.dacPair = pair_q;

  always_comb begin
    stateD = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (startReq) begin
          stateD = dacMode ? ST_DAC : ST_ADC;
        end
      end
      ST_ADC, ST_DAC: begin
        if (finish || abort) begin
          stateD = ST_IDLE;
        end
      end
      default: stateD = ST_IDLE;
    endcase
  end

  always_comb begin
    sarD = sar_q;
    if (startReq) begin
      sarD = CODE_ZERO;
    end else if (tickAdc && phase_q == PH_SAMPLE_END) begin
      sarD = CODE_MSB_TRIAL;
    end else if (tickAdc && phase_q > PH_SAMPLE_END) begin
      sarD = sarStep;
    end else if (dacBuildTick) begin
      sarD = dacBuilt;
    end
  end

  // formatted once at write time, so a later adjust change never reformats
  always_comb begin
    pairD = pair_q;
    if (adcEnd) begin
      pairD = fmtBus.adcPair;
    end else if (pairWrEn) begin
      if (pairWriteHigh) begin
        pairD[15:8] = pairWriteData;
      end
      if (pairWriteLow) begin
        pairD[7:0] = pairWriteData;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ZERO;
      sar_q <= CODE_ZERO;
      pair_q <= PAIR_RESET;
    end else begin
      state_q <= stateD;
      phase_q <= phaseD;
      sar_q <= sarD;
      pair_q <= pairD;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      go_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= 1'b0;
      hold_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      go_q <= goD;
      done_q <= doneD;
      irq_q <= finish;
      hold_q <= holdD;
      drive_q <= driveD;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dacBuf_q <= CODE_ZERO;
      muxCh_q <= CH_RESET;
      muxDiff_q <= 1'b0;
      muxConn_q <= 1'b0;
    end else if (startReq) begin
      // buffer frozen for the whole output conversion
      if (dacMode) begin
        dacBuf_q <= fmtBus.dacCode;
      end
      muxCh_q <= channelSelect;
      muxDiff_q <= differentialSelect && !dacMode;
      muxConn_q <= chanValid && !dacMode;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      compSync1_q <= 1'b0;
      compSync2_q <= 1'b0;
      rdHigh_q <= READ_BLANK;
      rdLow_q <= READ_BLANK;
    end else begin
      compSync1_q <= compAboveRaw;
      compSync2_q <= compSync1_q;
      rdHigh_q <= rdHighD;
      rdLow_q <= rdLowD;
    end
  end

  assign resultHighByte = rdHigh_q;
  assign resultLowByte = rdLow_q;
  assign conversionGoFlag = go_q;
  assign conversionDoneFlag = done_q;
  assign doneIrq = irq_q;
  assign sampleHold = hold_q;
  assign analogCode = sar_q;
  assign dacDrive = drive_q;
  assign muxChannel = muxCh_q;
  assign muxDiff = muxDiff_q;
  assign muxConnect = muxConn_q;

  // helper: system cycles spent in a run state, first-tick wait included
  localparam int ADC_RUN_MIN = ADC_CONV_CYCLES * TICK_DIV;
  localparam int ADC_RUN_MAX = ADC_RUN_MIN + TICK_DIV - 1;
  localparam int DAC_RUN_MIN = DAC_CONV_CYCLES * TICK_DIV;
  localparam int DAC_RUN_MAX = DAC_RUN_MIN + TICK_DIV - 1;
  logic [8:0] runCnt_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      runCnt_q <= 9'h000;
    end else begin
      runCnt_q <= idle ? 9'h000 : runCnt_q + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_accept;
    startReq;
  endsequence
  sequence s_busy;
    conversionGoFlag && (state_q != ST_IDLE);
  endsequence

  property p_go_start;
    s_accept |=> s_busy;
  endproperty
  a_go_start: assert property (p_go_start) else $error("go flag not set on start");

  property p_go_clear;
    doneIrq |-> !conversionGoFlag && idle;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go flag still set at end");

  property p_irq_pulse;
    finish |=> doneIrq ##1 !doneIrq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not one pulse");

  property p_done_wins;
    finish && doneClear |=> conversionDoneFlag;
  endproperty
  a_done_wins: assert property (p_done_wins) else $error("done lost to clear");

  property p_adc_len;
    adcEnd |-> runCnt_q inside {[ADC_RUN_MIN:ADC_RUN_MAX]};
  endproperty
  a_adc_len: assert property (p_adc_len) else $error("adc length wrong");

  property p_dac_len;
    dacEnd |-> runCnt_q inside {[DAC_RUN_MIN:DAC_RUN_MAX]};
  endproperty
  a_dac_len: assert property (p_dac_len) else $error("dac length wrong");

  property p_sample_cycle;
    $rose(sampleHold) |-> (state_q == ST_ADC) && (phase_q == PH_SAMPLE_END);
  endproperty
  a_sample_cycle: assert property (p_sample_cycle) else $error("sample not third");

  property p_buf_hold;
    (state_q == ST_DAC) && ($past(state_q) == ST_DAC) |-> $stable(dacBuf_q);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("dac buffer moved");

  property p_read_blank;
    dacMode ##1 dacMode |-> resultHighByte == READ_BLANK && resultLowByte == READ_BLANK;
  endproperty
  a_read_blank: assert property (p_read_blank) else $error("pair readable in dac");

  property p_pair_hold;
    !adcEnd && !pairWrAny |=> $stable(pair_q);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair changed unasked");

  property p_right_fmt;
    adcEnd && !leftAdjustSelect |=> pair_q[15:9] inside {7'h00, 7'h7F};
  endproperty
  a_right_fmt: assert property (p_right_fmt) else $error("sign not extended");

  property p_left_fmt;
    adcEnd && leftAdjustSelect |=> pair_q[5:0] == ZERO_FILL;
  endproperty
  a_left_fmt: assert property (p_left_fmt) else $error("low six not zero");

  property p_no_over;
    adcEnd |=> pair_q != RIGHT_OVERRANGE && pair_q != LEFT_OVERRANGE;
  endproperty
  a_no_over: assert property (p_no_over) else $error("code below -511");

  property p_mux_valid;
    muxConnect |-> (muxDiff ? muxChannel < DIFFERENTIAL_SELECT_PAIRS : muxChannel < SE_CHANNELS);
  endproperty
  a_mux_valid: assert property (p_mux_valid) else $error("bad channel connected");

  property p_timer_start;
    hwStart && converterEnableBit && idle |=> s_busy;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer start missed");
endmodule
`default_nettype wire

// File: testbench/conv_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module conv_analog_model (
  input wire logic core_clk,
  input wire logic [9:0] inLevel,
  input wire logic sampleHold,
  input wire logic muxConnect,
  input wire logic [9:0] analogCode,
  output logic compAboveRaw
);
  logic [9:0] held;
  initial held = 10'h000;
  // open switch keeps the old charge, like a real hold capacitor
  always @(posedge core_clk) begin
    if (sampleHold && muxConnect) begin
      held <= inLevel;
    end
  end
  // signed level shifted by half scale to match offset-binary trials
  assign compAboveRaw = ({~held[9], held[8:0]} >= analogCode);
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import conv_pkg::*;
  logic core_clk = 0, rst_b = 0, en = 0, dacMode = 0, leftAdj = 0, diffSel = 0;
  logic goSet = 0, timerTrig = 0, timerEn = 0, doneClear = 0, wrH = 0, wrL = 0;
  logic [2:0] chSel = 3'h0;
  logic [7:0] wrData = 8'h00;
  logic [9:0] level = 10'h000;
  wire logic compAbove, goFlag, doneFlag, doneIrq, sampleHold, dacDrive, muxDiff, muxConn;
  wire logic [7:0] hi, lo;
  wire logic [9:0] code;
  wire logic [2:0] muxCh;
  int mismatches = 0, totalChecks = 0, irqCount = 0, shCount = 0, n, i, k;
  int seed = 32'h7ed226c4;
  logic [9:0] tv [6] = '{10'h100, 10'h1FF, 10'h300, 10'h201, 10'h000, 10'h200};
  logic [15:0] tr [6] = '{16'h0100, 16'h01FF, 16'hFF00, 16'hFE01, 16'h0000, 16'hFE01};
  logic [15:0] tl [6] = '{16'h4000, 16'h7FC0, 16'hC000, 16'h8040, 16'h0000, 16'h8040};
  logic [9:0] rv;
  logic [2:0] rc;
  // negedges from the one after the start edge to the one that sees the irq
  localparam int ADC_LO = ADC_CONV_CYCLES * TICK_DIV + 2;
  localparam int ADC_HI = ADC_LO + TICK_DIV - 1;
  localparam int DAC_LO = DAC_CONV_CYCLES * TICK_DIV + 1;
  localparam int DAC_HI = DAC_LO + TICK_DIV - 1;

  conv_control DUT (.core_clk(core_clk), .rst_b(rst_b), .converterEnableBit(en),
    .dacMode(dacMode), .leftAdjustSelect(leftAdj), .differentialSelect(diffSel),
    .channelSelect(chSel), .goSet(goSet), .timerTrigger(timerTrig),
    .timerTrigEnable(timerEn), .doneClear(doneClear), .pairWriteHigh(wrH),
    .pairWriteLow(wrL), .pairWriteData(wrData), .compAboveRaw(compAbove),
    .resultHighByte(hi), .resultLowByte(lo), .conversionGoFlag(goFlag),
    .conversionDoneFlag(doneFlag), .doneIrq(doneIrq), .sampleHold(sampleHold),
    .analogCode(code), .dacDrive(dacDrive), .muxChannel(muxCh), .muxDiff(muxDiff),
    .muxConnect(muxConn));
  conv_analog_model partner (.core_clk(core_clk), .inLevel(level), .sampleHold(sampleHold),
    .muxConnect(muxConn), .analogCode(code), .compAboveRaw(compAbove));

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (doneIrq === 1'b1) irqCount++;
    if (sampleHold === 1'b1) shCount++;
  end

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task endOfTest;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // sign fold: the most negative code cannot be produced
  function automatic logic [15:0] expPair(input logic [9:0] v, input logic left);
    logic [9:0] s;
    s = (v == 10'h200) ? 10'h201 : v;
    return left ? {s, 6'h00} : {{6{s[9]}}, s};
  endfunction

  task pulseStart(input logic viaTimer);
    @(negedge core_clk);
    if (viaTimer) timerTrig = 1;
    else goSet = 1;
    doneClear = 1;
    @(negedge core_clk);
    goSet = 0;
    timerTrig = 0;
    doneClear = 0;
  endtask

  task waitDone(input int lo_, input int hi_);
    n = 0;
    while (doneIrq !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      endOfTest;
    end
    check("convTime", 16'(n >= lo_ && n <= hi_), 16'h0001);
    check("doneSet", 16'(doneFlag), 16'h0001);
    check("goCleared", 16'(goFlag), 16'h0000);
  endtask

  task runAdc(input logic [9:0] v, input logic [2:0] ch, input logic left,
      input logic conn, input logic [15:0] exp);
    level = v;
    chSel = ch;
    leftAdj = left;
    k = shCount;
    pulseStart(0);
    check("goSet", 16'(goFlag), 16'h0001);
    check("muxChannel", 16'(muxCh), 16'(ch));
    check("muxDiff", 16'(muxDiff), 16'(diffSel));
    check("muxConnect", 16'(muxConn), 16'(conn));
    waitDone(ADC_LO, ADC_HI);
    check("sampleLen", 16'(shCount - k), 16'(TICK_DIV));
    @(negedge core_clk);
    check("pair", {hi, lo}, exp);
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    check("resetPair", {hi, lo}, 16'h0000);
    rst_b = 1;
    en = 1;
    for (i = 0; i < 6; i++) begin
      runAdc(tv[i], 3'(i), 0, 1, tr[i]);
      runAdc(tv[i], 3'(i), 1, 1, tl[i]);
    end
    runAdc(10'h100, 3'h1, 1, 1, 16'h4000);
    leftAdj = 0;
    wrData = 8'h5A;
    wrH = 1;
    wrL = 1;
    @(negedge core_clk);
    wrH = 0;
    wrL = 0;
    repeat (2) @(negedge core_clk);
    check("noReformat", {hi, lo}, 16'h4000);
    // channel validity: keep level so an open switch changes nothing
    runAdc(10'h100, 3'h7, 0, 0, 16'h0100);
    diffSel = 1;
    runAdc(10'h100, 3'h2, 0, 1, 16'h0100);
    runAdc(10'h100, 3'h3, 0, 0, 16'h0100);
    diffSel = 0;
    // timer start, a second go while busy is dropped
    timerEn = 1;
    k = irqCount;
    pulseStart(1);
    check("timerGo", 16'(goFlag), 16'h0001);
    repeat (30) @(negedge core_clk);
    goSet = 1;
    @(negedge core_clk);
    goSet = 0;
    waitDone(ADC_LO - 31, ADC_HI - 31);
    repeat (300) @(negedge core_clk);
    check("busyIgnored", 16'(irqCount - k), 16'h0001);
    timerEn = 0;
    timerTrig = 1;
    @(negedge core_clk);
    timerTrig = 0;
    doneClear = 1;
    @(negedge core_clk);
    doneClear = 0;
    check("timerOff", 16'(goFlag), 16'h0000);
    check("doneClear", 16'(doneFlag), 16'h0000);
    en = 0;
    pulseStart(0);
    check("disabled", 16'(goFlag), 16'h0000);
    en = 1;
    for (i = 0; i < 8; i++) begin
      rv = 10'($random(seed));
      rc = 3'(($random(seed) & 32'h7FFF) % 7);
      k = $random(seed);
      runAdc(rv, rc, k[0], 1, expPair(rv, k[0]));
    end
    // output mode: pair write, buffer held against a mid-run write
    dacMode = 1;
    leftAdj = 0;
    wrData = 8'hAB;
    wrH = 1;
    @(negedge core_clk);
    wrH = 0;
    wrL = 1;
    wrData = 8'hCD;
    @(negedge core_clk);
    wrL = 0;
    @(negedge core_clk);
    check("dacReadBlank", {hi, lo}, 16'h0000);
    for (i = 0; i < 2; i++) begin
      pulseStart(0);
      wrData = 8'h00;
      wrH = 1;
      @(negedge core_clk);
      wrH = 0;
      // second run holds clear across completion: the set must win
      doneClear = (i == 1);
      waitDone(DAC_LO, DAC_HI);
      doneClear = 0;
      check("dacCode", 16'(code), i == 0 ? 16'h01CD : 16'h0203);
      check("dacDrive", 16'(dacDrive), 16'h0001);
      leftAdj = 1;
    end
    endOfTest;
  end
endmodule
`default_nettype wire
